// ### rdc_pkg.sv
package rdc_pkg;
  // clock and pulse timing
  localparam int CLK_NS    = 4;                              // clk period
  localparam int BUSY_NS   = 150;                            // least busy width
  localparam int CARRY_NS  = 300;                            // least carry width
  localparam int BUSY_CYC  = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CARRY_CYC = (CARRY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] BUSY_LEN  = 7'(BUSY_CYC);           // busy cycles
  localparam logic [6:0] CARRY_LEN = 7'(CARRY_CYC);          // carry cycles

  // error quanta per lsb, hysteresis threshold
  localparam logic signed [5:0] LSB_QUANTA = 6'sh04;         // quanta per lsb
  localparam logic signed [5:0] ACC_MAX    = 6'sh07;         // accumulator cap

  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;                    // resolution
  localparam logic [3:0] OFS_POS  = 4'h4;                    // live counter
  localparam logic [3:0] OFS_STAT = 4'h8;                    // status bits

  // resolution codes
  typedef enum logic [1:0] {
    RES_10 = 2'h0,
    RES_12 = 2'h1,
    RES_14 = 2'h2,
    RES_16 = 2'h3
  } res_t;
  localparam res_t RES_RESET = RES_12;                       // after reset

  // control pins travelling together
  typedef struct packed {
    logic load_n;                                            // preset strobe
    logic cmp_n;                                             // complement mode
    logic inh_n;                                             // latch freeze
    logic en_n;                                              // output enable
    logic up;                                                // error quantum up
    logic dn;                                                // error quantum dn
  } pins_t;
  localparam pins_t PINS_IDLE = 6'h3c;                       // strobes inactive

  // valid counter bits for a resolution
  function automatic logic [15:0] res_mask(res_t r);
    case (r)
      RES_10:  res_mask = 16'h03ff;
      RES_12:  res_mask = 16'h0fff;
      RES_14:  res_mask = 16'h3fff;
      default: res_mask = 16'hffff;
    endcase
  endfunction : res_mask
endpackage : rdc_pkg

// ### pin_sync.sv
`timescale 1ns/1ns
// three stage pin synchroniser with agreement filter
module pin_sync #(
  parameter int           W    = 1,                  // width
  parameter logic [W-1:0] INIT = '0                  // reset level
) (
  input  wire logic         clk_i,                   // system clock
  input  wire logic         rst_i,                   // sync reset
  input  wire logic [W-1:0] pin_i,                   // async pins
  output logic      [W-1:0] val_o                    // filtered level
);
  logic [W-1:0] s1_q, s2_q, s3_q, val_q, val_d;      // stages, result

  // a bit changes once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      val_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : val_q[i];
    end
  end

  // stage registers, reset to idle level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      val_q <= INIT;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      val_q <= val_d;
    end
  end

  assign val_o = val_q;
endmodule : pin_sync

// ### rdc_counter.sv
`timescale 1ns/1ns
// position counter, latches and readback of the tracking converter
module rdc_counter (
  input  wire logic         clk_i,           // 250 mhz clock
  input  wire logic         rst_i,           // sync reset, high
  input  rdc_pkg::pins_t    pins_i,          // control and quantum pins
  input  wire logic [15:0]  data_i,          // data pins, in
  output logic      [15:0]  data_o,          // data pins, out
  output logic              data_oe_o,       // data pins driven
  output logic              dir_o,           // rotation sense, 1 up
  output logic              busy_o,          // busy pulse
  output logic              carry_out_o,     // revolution carry
  input  wire logic [3:0]   adr_i,           // wishbone byte address
  input  wire logic [31:0]  dat_i,           // wishbone write data
  output logic      [31:0]  dat_o,           // wishbone read data
  input  wire logic [3:0]   sel_i,           // byte enables
  input  wire logic         we_i,            // write
  input  wire logic         cyc_i,           // cycle
  input  wire logic         stb_i,           // strobe
  output logic              ack_o            // acknowledge
);
  import rdc_pkg::*;

  pins_t              pin_f;                 // filtered pins
  logic [15:0]        din_f;                 // filtered data word
  logic               up_prev_q, dn_prev_q;  // quantum edge history
  logic signed [5:0]  acc_q, acc_d;          // sub-lsb error
  logic [15:0]        cnt_q, cnt_d;          // position counter
  logic [15:0]        latch_q, latch_d;      // output latch
  logic               dir_q, dir_d;          // direction flop
  logic [6:0]         busy_cnt_q, busy_cnt_d;
  logic [6:0]         car_cnt_q, car_cnt_d;
  logic               busy_q, busy_d;
  logic               car_q, car_d;
  logic               oe_q, oe_d;
  logic               inh_prev_q;            // inhibit history
  res_t               res_q, res_d;          // selected resolution
  logic               ack_q, ack_d;
  logic [31:0]        rd_q, rd_d;
  logic               q_up, q_dn;            // quantum events
  logic               load, step, step_up;   // counter actions
  logic [15:0]        mask;                  // valid bits
  logic [15:0]        mask_nx;               // valid bits after bus write
  logic               dir_old_q;             // dir one cycle back
  logic               wrap;                  // step crosses zero

  // complement idles high through reset value
  pin_sync #(.W(6), .INIT(PINS_IDLE)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (pins_i),
    .val_o (pin_f)
  );

  pin_sync #(.W(16), .INIT(16'h0000)) u_data_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (data_i),
    .val_o (din_f)
  );

  // event decode
  always_comb begin
    mask    = res_mask(res_q);
    mask_nx = res_mask(res_d);
    q_up    = pin_f.up & ~up_prev_q & ~(pin_f.dn & ~dn_prev_q);
    q_dn    = pin_f.dn & ~dn_prev_q & ~(pin_f.up & ~up_prev_q);
    load    = ~pin_f.load_n;
    // step only with a full lsb of error in dir sense
    step_up = dir_q;
    // a fresh sense change waits one cycle, so dir leads the step
    step    = ~load & ~busy_q & (dir_q == dir_old_q) &
              ((dir_q & (acc_q >= LSB_QUANTA)) |
               (~dir_q & (acc_q <= -LSB_QUANTA)));
    wrap    = step_up ? (cnt_q == mask) : (cnt_q == 16'h0000);
  end

  // next state of the tracking core
  always_comb begin
    acc_d      = acc_q;
    cnt_d      = cnt_q & mask;
    dir_d      = dir_q;
    busy_cnt_d = busy_cnt_q;
    car_cnt_d  = car_cnt_q;
    latch_d    = latch_q & mask_nx;
    // each quantum sets the sense at once
    if (q_up) begin
      dir_d = 1'b1;
      acc_d = (acc_q < ACC_MAX) ? acc_q + 6'sh01 : acc_q;
    end else if (q_dn) begin
      dir_d = 1'b0;
      acc_d = (acc_q > -ACC_MAX) ? acc_q - 6'sh01 : acc_q;
    end
    if (load) begin
      // preset path, complement clears the bits set in the data word
      if (~pin_f.cmp_n) begin
        cnt_d = cnt_q & ~din_f & mask;
      end else begin
        cnt_d = din_f & mask;
      end
    end else if (step) begin
      // dir already stood a cycle before this step
      if (step_up) begin
        cnt_d = 16'(cnt_q + 16'h0001) & mask;
        acc_d = acc_d - LSB_QUANTA;
      end else begin
        cnt_d = 16'(cnt_q - 16'h0001) & mask;
        acc_d = acc_d + LSB_QUANTA;
      end
    end
    // clip with the resolution that stands next cycle
    cnt_d = cnt_d & mask_nx;
    // busy pulse per step or inhibit release
    if (step | (pin_f.inh_n & ~inh_prev_q)) begin
      busy_cnt_d = BUSY_LEN;
    end else if (busy_cnt_q != 7'h00) begin
      busy_cnt_d = busy_cnt_q - 7'h01;
    end
    if (step & wrap) begin
      car_cnt_d = CARRY_LEN;
    end else if (car_cnt_q != 7'h00) begin
      car_cnt_d = car_cnt_q - 7'h01;
    end
    busy_d = busy_cnt_d != 7'h00;
    car_d  = car_cnt_d != 7'h00;
    // latch copies counter unless frozen
    if (pin_f.inh_n) begin
      latch_d = cnt_d;
    end
    oe_d = ~pin_f.en_n;
  end

  // tracking core registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q      <= 6'sh00;
      cnt_q      <= 16'h0000;
      dir_q      <= 1'b1;
      dir_old_q  <= 1'b1;
      busy_cnt_q <= 7'h00;
      car_cnt_q  <= 7'h00;
      busy_q     <= 1'b0;
      car_q      <= 1'b0;
      latch_q    <= 16'h0000;
      oe_q       <= 1'b0;
      up_prev_q  <= 1'b0;
      dn_prev_q  <= 1'b0;
      inh_prev_q <= 1'b1;
    end else begin
      acc_q      <= acc_d;
      cnt_q      <= cnt_d;
      dir_q      <= dir_d;
      dir_old_q  <= dir_q;
      busy_cnt_q <= busy_cnt_d;
      car_cnt_q  <= car_cnt_d;
      busy_q     <= busy_d;
      car_q      <= car_d;
      latch_q    <= latch_d;
      oe_q       <= oe_d;
      up_prev_q  <= pin_f.up;
      dn_prev_q  <= pin_f.dn;
      inh_prev_q <= pin_f.inh_n;
    end
  end

  // wishbone slave: ack one cycle after request
  always_comb begin
    res_d = res_q;
    ack_d = cyc_i & stb_i & ~ack_q;
    rd_d  = rd_q;
    if (ack_d) begin
      rd_d = 32'h0000_0000;                              // unmapped reads zero
      case (adr_i)
        OFS_CTRL: rd_d = {30'h0, res_q};
        OFS_POS:  rd_d = {16'h0, cnt_q};
        OFS_STAT: rd_d = {22'h0, dir_q, busy_q, car_q, oe_q, acc_q};
        default:  rd_d = 32'h0000_0000;
      endcase
      if (we_i & sel_i[0] & (adr_i == OFS_CTRL)) begin
        res_d = res_t'(dat_i[1:0]);
      end
    end
  end

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_q <= RES_RESET;
      ack_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end else begin
      res_q <= res_d;
      ack_q <= ack_d;
      rd_q  <= rd_d;
    end
  end

  assign data_o      = latch_q;
  assign data_oe_o   = oe_q;
  assign dir_o       = dir_q;
  assign busy_o      = busy_q;
  assign carry_out_o = car_q;
  assign dat_o       = rd_q;
  assign ack_o       = ack_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_step_busy: assert property (step |=> busy_o [*8])
    else $error("busy not raised for a step");
  chk_dir_lead: assert property (step |-> dir_o == $past(dir_o))
    else $error("dir changed with its step");
  chk_wrap_carry: assert property (step && wrap |=> carry_out_o)
    else $error("carry missing on wrap");
  chk_freeze_latch: assert property (!pin_f.inh_n |=> $stable(latch_q))
    else $error("latch moved while frozen");
  chk_enable_float: assert property (pin_f.en_n |=> !data_oe_o)
    else $error("pins driven while disabled");
  chk_bit_clear: assert property (load && !pin_f.cmp_n |=>
      cnt_q == ($past(cnt_q) & ~$past(din_f) & $past(mask)))
    else $error("complement load wrong");
  chk_full_load: assert property (load && pin_f.cmp_n |=>
      cnt_q == ($past(din_f) & $past(mask)))
    else $error("plain load wrong");
  chk_high_zero: assert property ((cnt_q & ~mask) == 16'h0000)
    else $error("bits above resolution set");
  chk_hyst_step: assert property (step |-> acc_q >= LSB_QUANTA ||
      acc_q <= -LSB_QUANTA)
    else $error("step below one lsb");
  chk_up_count: assert property (step && step_up && res_d == res_q |=>
      cnt_q == (16'($past(cnt_q) + 16'h0001) & mask))
    else $error("up step not plus one");
endmodule : rdc_counter

// ### host_pins.sv
`timescale 1ns/1ns
// host side of the control and data pins
module host_pins (
  input  wire logic      clk_i,  // system clock
  output rdc_pkg::pins_t pins_o, // control and quantum pins
  output logic [15:0]    d_o     // host side of data pins
);
  import rdc_pkg::*;
  logic [15:0] word_q; // last word offered
  logic        oe_q;   // host drives data pins
  // complement idles high, as the pull-up would leave it
  initial begin
    pins_o = PINS_IDLE;
    word_q = 16'h0000;
    oe_q   = 1'b0;
  end
  // released pins read as inverse of the last word
  assign d_o = oe_q ? word_q : ~word_q;
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_n
  // float outputs, offer word, strobe, hold, release, read back
  task automatic preset(input logic [15:0] w, input logic clr);
    wait_n(1);
    pins_o.en_n <= 1'b1;
    wait_n(8);
    word_q <= w;
    oe_q   <= 1'b1;
    wait_n(2);
    pins_o.load_n <= 1'b0;
    pins_o.cmp_n  <= ~clr;
    wait_n(40); // hold covers 100 ns plus the pin filter
    pins_o.load_n <= 1'b1;
    pins_o.cmp_n  <= 1'b1;
    wait_n(8);
    oe_q <= 1'b0;
    wait_n(2);
    pins_o.en_n <= 1'b0;
    wait_n(8);
  endtask : preset
  // n error quanta in one sense, then let busy run out
  task automatic quanta(input int n, input logic up);
    repeat (n) begin
      wait_n(1);
      if (up) pins_o.up <= 1'b1;
      else pins_o.dn <= 1'b1;
      wait_n(6);
      pins_o.up <= 1'b0;
      pins_o.dn <= 1'b0;
      wait_n(5);
    end
    wait_n(60);
  endtask : quanta
  // latch freeze and output enable levels
  task automatic levels(input logic inh, input logic en);
    wait_n(1);
    pins_o.inh_n <= inh;
    pins_o.en_n  <= en;
    wait_n(60);
  endtask : levels
endmodule : host_pins

// ### tracking_position_counter_preset_tb.sv
`timescale 1ns/1ns
// self-checking bench with an integer model of the counter
module tracking_position_counter_preset_tb;
  import rdc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, rd;
  logic [15:0] data_o, h_d, data_w;
  logic        data_oe_o, dir_o, busy_o, carry_out_o, ack_o;
  logic        busy_q = 1'b0, carry_q = 1'b0, frz = 1'b0;
  pins_t       pins;
  logic [31:0] seed = 32'h16d6e;
  int err_count = 0, n_compared = 0, busy_n = 0, carry_n = 0;
  int cnt = 0, mask = 32'h0fff, lat = 0, exp_busy = 0, exp_carry = 0;
  always #2 clk_i = ~clk_i;
  // resolved data pins: device drives when enabled, else host
  assign data_w = data_oe_o ? data_o : h_d;
  host_pins u_host (.clk_i(clk_i), .pins_o(pins), .d_o(h_d));
  rdc_counter u_dut (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
    .data_i(data_w), .data_o(data_o), .data_oe_o(data_oe_o),
    .dir_o(dir_o), .busy_o(busy_o), .carry_out_o(carry_out_o),
    .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o));
  // count rising edges of busy and carry
  always @(posedge clk_i) begin
    busy_q  <= busy_o;
    carry_q <= carry_out_o;
    if (busy_o === 1'b1 && busy_q === 1'b0) busy_n++;
    if (carry_out_o === 1'b1 && carry_q === 1'b0) carry_n++;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [31:0] wd, output logic [31:0] r);
    int t;
    @(posedge clk_i);
    adr <= a;
    we  <= w;
    dat <= wd;
    sel <= 4'(xs()) | 4'h1;
    cyc <= 1'b1;
    stb <= 1'b1;
    t = 0;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 100);
    if (t >= 100) err_count++;
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task automatic check_all();
    logic [31:0] r;
    wb(4'h4, 1'b0, 32'h0, r);
    chk("pos", r, 32'(cnt));
    chk("latch", 32'(data_o), 32'(lat));
    chk("busy", 32'(busy_n), 32'(exp_busy));
    chk("carry", 32'(carry_n), 32'(exp_carry));
  endtask : check_all
  // n quanta, the last of which completes one lsb of error
  task automatic step(input logic up, input int n);
    u_host.quanta(n, up);
    cnt = up ? cnt + 1 : cnt - 1;
    if ((cnt & ~mask) != 0) exp_carry++; // wrap in either sense
    cnt &= mask;
    exp_busy++;
    if (!frz) lat = cnt;
    chk("dir", 32'(dir_o), 32'(up));
    check_all();
  endtask : step
  task automatic load(input logic [15:0] w, input logic clr);
    u_host.preset(w, clr);
    cnt = (clr ? cnt & ~int'(w) : int'(w)) & mask;
    lat = cnt;
    chk("oe", 32'(data_oe_o), 32'h1);
    check_all();
  endtask : load
  // hang guard
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(4'h0, 1'b0, 32'h0, rd);
    chk("ctrl", rd, 32'(RES_RESET));
    chk("dir0", 32'(dir_o), 32'h1);
    chk("oe0", 32'(data_oe_o), 32'h0);
    wb(4'h8, 1'b0, 32'h0, rd);
    chk("stat0", rd, 32'h200);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      wb(4'h0, 1'b1, 32'(r), rd);
      mask = (1 << (10 + 2 * r)) - 1;
      load(16'hffff, 1'b0);
      step(1'b1, 4);
      step(1'b0, 4);
    end
    wb(4'h0, 1'b1, 32'h1, rd);
    mask = 32'h0fff;
    cnt &= mask;
    lat = cnt;
    check_all();
    $display("test resolution done");
    u_host.quanta(3, 1'b1);
    check_all();
    step(1'b1, 1);
    u_host.quanta(1, 1'b0);
    chk("dir_dn", 32'(dir_o), 32'h0);
    u_host.quanta(1, 1'b1);
    chk("dir_up", 32'(dir_o), 32'h1);
    check_all();
    wb(4'h8, 1'b0, 32'h0, rd);
    chk("stat", rd, 32'h240);
    $display("test hysteresis done");
    u_host.levels(1'b0, 1'b0);
    frz = 1'b1;
    step(1'b1, 4);
    u_host.levels(1'b1, 1'b1);
    chk("oe_off", 32'(data_oe_o), 32'h0);
    frz = 1'b0;
    lat = cnt;
    exp_busy++;
    u_host.levels(1'b1, 1'b0);
    chk("oe_on", 32'(data_oe_o), 32'h1);
    check_all();
    $display("test inhibit done");
    wb(4'hc, 1'b1, 32'hffffffff, rd);
    wb(4'hc, 1'b0, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    wb(4'h4, 1'b1, 32'h5, rd);
    check_all();
    $display("test bus done");
    repeat (3) begin
      load(16'(xs()), 1'b0);
      load(16'(xs()), 1'b1);
    end
    $display("test preset done");
    end_of_test();
  end
endmodule : tracking_position_counter_preset_tb
